/* hw/dcc_pkg.sv */
package dcc_pkg;

   // Register offsets on the serial bus, indexed by channel
   localparam logic [1:0][7:0] CTL_ADDR      = {8'hD4, 8'hD0};
   localparam logic [1:0][7:0] ALE_ADDR      = {8'hD5, 8'hD1};
   localparam logic [1:0][7:0] STS_ADDR      = {8'hD6, 8'hD2};

   // Control register fields
   localparam int              CTL_MODE_HI   = 7;
   localparam int              CTL_MODE_LO   = 6;
   localparam int              CTL_PIN_DATA  = 5;
   localparam int              CTL_BCAST_EN  = 4;
   localparam int              CTL_FET_ON    = 3;
   localparam int              CTL_RETRY_OC  = 2;
   localparam int              CTL_RETRY_LO  = 1;
   localparam int              CTL_RETRY_HI  = 0;

   // Status fields; alert-enable and fault log share bits 5..0
   localparam int              STS_FET_ON    = 7;
   localparam int              STS_PIN       = 6;
   localparam int              STS_SHORT     = 5;
   localparam int              STS_CARD      = 4;
   localparam int              STS_PBAD      = 3;
   localparam int              STS_OC        = 2;
   localparam int              STS_LO_TH     = 1;
   localparam int              STS_HI_TH     = 0;

   // Reset values and writable-bit masks; control ones indexed by channel, alert-enable ones shared
   localparam logic [1:0][7:0] CTL_RESET     = {8'h37, 8'h27};
   localparam logic [1:0][7:0] CTL_WMASK     = {8'hFF, 8'hEF};
   localparam logic [7:0]      ALE_RESET     = 8'h00;
   localparam logic [7:0]      ALE_WMASK     = 8'h3F;

   // Serial bus addresses
   localparam logic [6:0]      DEV_ADDR      = 7'h44;
   localparam logic [7:0]      BCAST_ADDR    = 8'hC6;
   localparam logic [7:0]      ARA_ADDR      = 8'h19;

   // Timing
   localparam int              CLK_MHZ       = 50;
   localparam int              DEBOUNCE_US   = 100;

   // General pin use
   typedef enum logic [1:0] {
      PM_PGOOD_INV = 2'b00,
      PM_PGOOD     = 2'b01,
      PM_OUTPUT    = 2'b10,
      PM_INPUT     = 2'b11
   } dcc_pin_mode_t;

   // Serial slave states
   typedef enum logic [2:0] {
      BS_IDLE   = 3'b000,
      BS_RX     = 3'b001,
      BS_RX_ACK = 3'b010,
      BS_TX     = 3'b011,
      BS_TX_ACK = 3'b100
   } dcc_bus_state_t;

endpackage : dcc_pkg

/* hw/dcc_serial_slave.sv */
`timescale 1ns/1ns
`default_nettype none

module dcc_serial_slave
   import dcc_pkg::*;
(
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       bcast_en_in,
   input  wire logic       alert_active_in,
   input  wire logic [7:0] rd_data_in,
   output logic            sda_oe_out,
   output logic            wr_stb_out,
   output logic [7:0]      wr_data_out,
   output logic [7:0]      reg_ptr_out,
   output logic            addressed_out,
   output logic            ara_done_out
);

   logic           scl_q1, scl_q2, scl_q3;
   logic           sda_q1, sda_q2, sda_q3;
   logic           scl_rise, scl_fall, bus_start, bus_stop;
   dcc_bus_state_t state;
   logic [3:0]     bit_cnt;
   logic [7:0]     shreg;
   logic [7:0]     tx_byte;
   logic           first_byte, cmd_next, rd_mode, ara_mode, more;

   // Pin synchronisers plus one history stage for edges
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         scl_q1 <= 1'b1;
         scl_q2 <= 1'b1;
         scl_q3 <= 1'b1;
         sda_q1 <= 1'b1;
         sda_q2 <= 1'b1;
         sda_q3 <= 1'b1;
      end else begin
         scl_q1 <= scl_in;
         scl_q2 <= scl_q1;
         scl_q3 <= scl_q2;
         sda_q1 <= sda_in;
         sda_q2 <= sda_q1;
         sda_q3 <= sda_q2;
      end
   end

   // Bus events
   assign scl_rise  = scl_q2 & ~scl_q3;
   assign scl_fall  = ~scl_q2 & scl_q3;
   assign bus_start = scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
   assign bus_stop  = scl_q2 & scl_q3 & ~sda_q3 & sda_q2;
   assign tx_byte   = ara_mode ? {DEV_ADDR, 1'b0} : rd_data_in;

   // Byte engine: address, command pointer, data
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state         <= BS_IDLE;
         bit_cnt       <= 4'h0;
         shreg         <= 8'h00;
         first_byte    <= 1'b0;
         cmd_next      <= 1'b0;
         rd_mode       <= 1'b0;
         ara_mode      <= 1'b0;
         more          <= 1'b0;
         sda_oe_out    <= 1'b0;
         wr_stb_out    <= 1'b0;
         wr_data_out   <= 8'h00;
         reg_ptr_out   <= 8'h00;
         addressed_out <= 1'b0;
         ara_done_out  <= 1'b0;
      end else begin
         wr_stb_out    <= 1'b0;
         addressed_out <= 1'b0;
         ara_done_out  <= 1'b0;
         if (bus_start) begin
            state      <= BS_RX;
            bit_cnt    <= 4'h0;
            first_byte <= 1'b1;
            sda_oe_out <= 1'b0;
         end else if (bus_stop) begin
            state      <= BS_IDLE;
            sda_oe_out <= 1'b0;
         end else begin
            case (state)
               BS_RX: begin
                  if (scl_rise && bit_cnt != 4'h8) begin
                     shreg   <= {shreg[6:0], sda_q2};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     if (first_byte) begin
                        first_byte <= 1'b0;
                        cmd_next   <= 1'b1;
                        if (shreg[7:1] == DEV_ADDR) begin
                           sda_oe_out    <= 1'b1;
                           rd_mode       <= shreg[0];
                           ara_mode      <= 1'b0;
                           addressed_out <= 1'b1;
                           state         <= BS_RX_ACK;
                        end else if (shreg == BCAST_ADDR && bcast_en_in) begin
                           sda_oe_out <= 1'b1;
                           rd_mode    <= 1'b0;
                           ara_mode   <= 1'b0;
                           state      <= BS_RX_ACK;
                        end else if (shreg == ARA_ADDR && alert_active_in) begin
                           sda_oe_out <= 1'b1;
                           rd_mode    <= 1'b1;
                           ara_mode   <= 1'b1;
                           state      <= BS_RX_ACK;
                        end else begin
                           state <= BS_IDLE;
                        end
                     end else begin
                        sda_oe_out <= 1'b1;
                        state      <= BS_RX_ACK;
                        if (cmd_next) begin
                           reg_ptr_out <= shreg;
                           cmd_next    <= 1'b0;
                        end else begin
                           wr_data_out <= shreg;
                           wr_stb_out  <= 1'b1;
                        end
                     end
                  end
               end
               BS_RX_ACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (rd_mode) begin
                        shreg      <= tx_byte;
                        sda_oe_out <= ~tx_byte[7];
                        state      <= BS_TX;
                     end else begin
                        sda_oe_out <= 1'b0;
                        state      <= BS_RX;
                     end
                  end
               end
               BS_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h7) begin
                        sda_oe_out   <= 1'b0;
                        state        <= BS_TX_ACK;
                        ara_done_out <= ara_mode;
                     end else begin
                        shreg      <= {shreg[6:0], 1'b0};
                        sda_oe_out <= ~shreg[6];
                        bit_cnt    <= bit_cnt + 4'h1;
                     end
                  end
               end
               BS_TX_ACK: begin
                  if (scl_rise) begin
                     more <= ~sda_q2;
                  end else if (scl_fall) begin
                     if (more) begin
                        shreg      <= tx_byte;        // Read word repeats the register
                        sda_oe_out <= ~tx_byte[7];
                        bit_cnt    <= 4'h0;
                        state      <= BS_TX;
                     end else begin
                        state <= BS_IDLE;
                     end
                  end
               end
               default: begin
                  state <= BS_IDLE;
               end
            endcase
         end
      end
   end

endmodule : dcc_serial_slave

`default_nettype wire

/* hw/dcc_regs.sv */
// Contract
// - Mode field selects power-good, output or input
// - Output mode: bit 5 high-Z or low
// - Channel 2 bit 4 enables broadcast writes
// - Bit 3 drives transistor, loads debounced request
// - Bit 2 selects overcurrent retry or latch
// - Bit 1 selects undervoltage retry or latch
// - Bit 0 selects overvoltage retry or latch
// - Alert enables for short and card change
// - Alert enables for power bad, three faults
// - All alert enables reset to zero
// - Status 7 shows transistor on
// - Status 6 shows general pin level
// - Status 5 shows transistor short present
// - Status 4 high when card input low
// - Status 3 high when feedback low
// - Status 2 shows overcurrent present
// - Status 1 high when low threshold low
// - Status 0 high when high threshold high
// - Status is read-only, writes ignored
// - Enabled new fault pulls alert low once
// - Alert released by response or addressing
`timescale 1ns/1ns
`default_nettype none

module dcc_regs
   import dcc_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ
)
(
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic [1:0] general_pin_in,
   output logic      [1:0] general_pin_out,
   output logic      [1:0] general_pin_oe_out,
   input  wire logic [1:0] card_present_input_n_in,
   input  wire logic [1:0] output_feedback_pin_in,
   input  wire logic [1:0] input_low_threshold_in,
   input  wire logic [1:0] input_high_threshold_in,
   input  wire logic [1:0] overcurrent_in,
   input  wire logic [1:0] transistor_short_in,
   input  wire logic       power_up_request_in,
   input  wire logic [5:0] fault_log_ch1_in,
   input  wire logic [5:0] fault_log_ch2_in,
   output logic      [1:0] fet_on_out,
   output logic      [1:0] retry_overcurrent_out,
   output logic      [1:0] retry_undervoltage_out,
   output logic      [1:0] retry_overvoltage_out,
   output logic            alert_out,
   output logic            alert_oe_out
);

   logic [7:0]  ctrl_r   [2];
   logic [7:0]  alen_r   [2];
   logic [7:0]  status_w [2];
   logic [5:0]  fault_log[2];
   logic [5:0]  fire     [2];
   logic [7:0]  rd_data;
   logic [7:0]  reg_ptr;
   logic [7:0]  wr_data;
   logic        wr_stb;
   logic        addressed;
   logic        ara_done;
   logic        req_q1, req_q2;
   logic        req_stable;
   logic        req_load;
   logic [15:0] deb_cnt;
   logic        fire_any;

   assign fault_log[0] = fault_log_ch1_in;
   assign fault_log[1] = fault_log_ch2_in;

   // Serial bus front end
   dcc_serial_slave u_slave (
      .core_clk_in     (core_clk_in),
      .rst_in          (rst_in),
      .scl_in          (scl_in),
      .sda_in          (sda_in),
      .bcast_en_in     (ctrl_r[1][CTL_BCAST_EN]),
      .alert_active_in (alert_oe_out),
      .rd_data_in      (rd_data),
      .sda_oe_out      (sda_oe_out),
      .wr_stb_out      (wr_stb),
      .wr_data_out     (wr_data),
      .reg_ptr_out     (reg_ptr),
      .addressed_out   (addressed),
      .ara_done_out    (ara_done)
   );

   // Open-drain data line only ever pulls low
   always_ff @(posedge core_clk_in) begin
      sda_out   <= 1'b0;
      alert_out <= 1'b0;
   end

   // Power-up request synchroniser
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         req_q1 <= 1'b0;
         req_q2 <= 1'b0;
      end else begin
         req_q1 <= power_up_request_in;
         req_q2 <= req_q1;
      end
   end

   // Debounce: a new level must hold for the full delay
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         deb_cnt    <= 16'h0000;
         req_stable <= 1'b0;
         req_load   <= 1'b0;
      end else begin
         req_load <= 1'b0;
         if (req_q2 != req_stable) begin
            if (deb_cnt == 16'(DEBOUNCE_CYCLES - 1)) begin
               deb_cnt    <= 16'h0000;
               req_stable <= req_q2;
               req_load   <= 1'b1;
            end else begin
               deb_cnt <= deb_cnt + 16'h0001;
            end
         end else begin
            deb_cnt <= 16'h0000;
         end
      end
   end

   // Per-channel registers, status and pin drive
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      logic [6:0]    pin_raw, pin_q1, pin_q2;
      logic          gp_lvl, short_lvl, card_n_lvl, fdbk_lvl, oc_lvl, lo_th_lvl, hi_th_lvl;
      logic          ctl_hit, ale_hit;
      logic [5:0]    alerted;
      dcc_pin_mode_t mode;

      assign pin_raw = {general_pin_in[ch], transistor_short_in[ch],
                        card_present_input_n_in[ch], output_feedback_pin_in[ch],
                        overcurrent_in[ch], input_low_threshold_in[ch],
                        input_high_threshold_in[ch]};

      // Two-stage synchroniser on all channel pins
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            pin_q1 <= 7'h00;
            pin_q2 <= 7'h00;
         end else begin
            pin_q1 <= pin_raw;
            pin_q2 <= pin_q1;
         end
      end

      assign {gp_lvl, short_lvl, card_n_lvl, fdbk_lvl, oc_lvl, lo_th_lvl, hi_th_lvl} = pin_q2;

      // Live status, no storage so writes cannot touch it
      assign status_w[ch][STS_FET_ON] = ctrl_r[ch][CTL_FET_ON];
      assign status_w[ch][STS_PIN]    = gp_lvl;
      assign status_w[ch][STS_SHORT]  = short_lvl;
      assign status_w[ch][STS_CARD]   = ~card_n_lvl;
      assign status_w[ch][STS_PBAD]   = ~fdbk_lvl;
      assign status_w[ch][STS_OC]     = oc_lvl;
      assign status_w[ch][STS_LO_TH]  = ~lo_th_lvl;
      assign status_w[ch][STS_HI_TH]  = hi_th_lvl;

      assign ctl_hit = wr_stb && (reg_ptr == CTL_ADDR[ch]);
      assign ale_hit = wr_stb && (reg_ptr == ALE_ADDR[ch]);

      // Control register; debounced request overrides bit 3
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            ctrl_r[ch] <= CTL_RESET[ch];
         end else begin
            if (ctl_hit) begin
               ctrl_r[ch] <= wr_data & CTL_WMASK[ch];
            end
            if (req_load) begin
               ctrl_r[ch][CTL_FET_ON] <= req_stable;
            end
         end
      end

      // Alert-enable register
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            alen_r[ch] <= ALE_RESET;
         end else if (ale_hit) begin
            alen_r[ch] <= wr_data & ALE_WMASK;
         end
      end

      // One alert per fault until its log bit clears
      assign fire[ch] = fault_log[ch] & alen_r[ch][5:0] & ~alerted;

      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            alerted <= 6'h00;
         end else begin
            alerted <= (alerted | fire[ch]) & fault_log[ch];
         end
      end

      assign mode = dcc_pin_mode_t'(ctrl_r[ch][CTL_MODE_HI:CTL_MODE_LO]);

      // General pin drive, open drain
      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            general_pin_out[ch]    <= 1'b0;
            general_pin_oe_out[ch] <= 1'b0;
         end else begin
            general_pin_out[ch] <= 1'b0;
            case (mode)
               PM_PGOOD_INV: general_pin_oe_out[ch] <= ~fdbk_lvl;
               PM_PGOOD:     general_pin_oe_out[ch] <= fdbk_lvl;
               PM_OUTPUT:    general_pin_oe_out[ch] <=
                                ~ctrl_r[ch][CTL_PIN_DATA];
               PM_INPUT:     general_pin_oe_out[ch] <= 1'b0;
               default:      general_pin_oe_out[ch] <= 1'b0;
            endcase
         end
      end

      // Control outputs straight from the register
      assign fet_on_out[ch]             = ctrl_r[ch][CTL_FET_ON];
      assign retry_overcurrent_out[ch]  = ctrl_r[ch][CTL_RETRY_OC];
      assign retry_undervoltage_out[ch] = ctrl_r[ch][CTL_RETRY_LO];
      assign retry_overvoltage_out[ch]  = ctrl_r[ch][CTL_RETRY_HI];
   end

   // Register read mux; unmapped offsets read zero
   always_comb begin
      rd_data = 8'h00;
      for (int ch = 0; ch < 2; ch++) begin
         if (reg_ptr == CTL_ADDR[ch]) begin
            rd_data = ctrl_r[ch];
         end
         if (reg_ptr == ALE_ADDR[ch]) begin
            rd_data = alen_r[ch];
         end
         if (reg_ptr == STS_ADDR[ch]) begin
            rd_data = status_w[ch];
         end
      end
   end

   assign fire_any = |{fire[0], fire[1]};

   // Alert line: a new fault wins over a release in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         alert_oe_out <= 1'b0;
      end else if (fire_any) begin
         alert_oe_out <= 1'b1;
      end else if (ara_done || addressed) begin
         alert_oe_out <= 1'b0;
      end
   end

endmodule : dcc_regs

`default_nettype wire

/* verif/dcc_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_regs_chk #(
   parameter int DEBOUNCE_CYCLES = 8
)
(
   input wire logic       core_clk_in,
   input wire logic       rst_in,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic [1:0] general_pin_out,
   input wire logic       power_up_request_in,
   input wire logic [5:0] fault_log_ch1_in,
   input wire logic [5:0] fault_log_ch2_in,
   input wire logic [1:0] fet_on_out,
   input wire logic [1:0] retry_overcurrent_out,
   input wire logic [1:0] retry_undervoltage_out,
   input wire logic [1:0] retry_overvoltage_out,
   input wire logic       alert_out,
   input wire logic       alert_oe_out
);
   logic       req_q;
   logic [7:0] held;
   default clocking @(posedge core_clk_in); endclocking
   // Cycles since the power-up request last moved
   always_ff @(posedge core_clk_in) begin
      req_q <= power_up_request_in;
      if (rst_in || power_up_request_in != req_q) held <= 8'h00;
      else if (held != 8'hFF) held <= held + 8'h01;
   end
   // Serial clock low: register updates and line changes belong here
   sequence s_bus_low;
      !scl_in;
   endsequence
   a_reset_ctl: assert property (rst_in |=> fet_on_out == 2'b00 &&
      {retry_overcurrent_out, retry_undervoltage_out, retry_overvoltage_out} == 6'h3F)
      else $error("control outputs wrong after reset");
   a_reset_oe: assert property (rst_in |=> !alert_oe_out && !sda_oe_out)
      else $error("open-drain enables high after reset");
   a_od_zero: assert property (disable iff (rst_in)
      sda_out == 1'b0 && alert_out == 1'b0 && general_pin_out == 2'b00)
      else $error("open-drain output drives high");
   a_alert_cause: assert property (disable iff (rst_in) $rose(alert_oe_out) |->
      ($past(fault_log_ch1_in) | $past(fault_log_ch2_in)) != 6'h00)
      else $error("alert without a logged fault");
   a_alert_release: assert property (disable iff (rst_in) $fell(alert_oe_out) |-> s_bus_low)
      else $error("alert released outside a bus transfer");
   a_debounce_load: assert property (disable iff (rst_in)
      held == 8'(DEBOUNCE_CYCLES + 6) |-> fet_on_out == {2{power_up_request_in}})
      else $error("transistor control missed debounced request");
   a_retry_on_bus: assert property (disable iff (rst_in)
      !$stable({retry_overcurrent_out, retry_undervoltage_out, retry_overvoltage_out})
      |-> s_bus_low) else $error("retry bits changed without a write");
   a_fet_cause: assert property (disable iff (rst_in) !$stable(fet_on_out) |->
      (s_bus_low or (fet_on_out == {2{power_up_request_in}})))
      else $error("transistor control changed without cause");
endmodule : dcc_regs_chk
`default_nettype wire

/* verif/dcc_host.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_host (
   input  wire logic clk_in,
   input  wire logic sda_in,
   output var logic  scl_out,
   output var logic  sda_out
);
   // Bus idles released
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk_in);
   endtask : w
   // One bit: data set mid-low, sampled at end of high
   task automatic bit_io(input logic b, output logic r);
      w(4);
      sda_out <= b;
      w(4);
      scl_out <= 1'b1;
      w(8);
      r = sda_in;
      scl_out <= 1'b0;
   endtask : bit_io
   task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack_n);
      for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
      bit_io(1'b1, ack_n);
   endtask : byte_io
   task automatic start();
      w(4);
      sda_out <= 1'b1;
      w(4);
      scl_out <= 1'b1;
      w(8);
      sda_out <= 1'b0;
      w(8);
      scl_out <= 1'b0;
   endtask : start
   task automatic stop();
      w(4);
      sda_out <= 1'b0;
      w(4);
      scl_out <= 1'b1;
      w(8);
      sda_out <= 1'b1;
      w(8);
   endtask : stop
   // Pointer write then data write, or repeated start and one read byte
   task automatic xact(input logic [7:0] a, p, d, input logic rd,
                       output logic [7:0] q, output logic nak);
      logic [7:0] r;
      logic       n0, n1, n2;
      start();
      byte_io(a, r, n0);
      byte_io(p, r, n1);
      if (rd) begin
         start();
         byte_io(a | 8'h01, r, n2);
         byte_io(8'hFF, q, r[0]);
      end else byte_io(d, r, n2);
      stop();
      nak = n0 | n1 | n2;
   endtask : xact
   // Alert response read of the responding address
   task automatic ara(output logic [7:0] q, output logic nak);
      logic [7:0] r;
      start();
      byte_io(8'h19 | 8'h01, r, nak);
      byte_io(8'hFF, q, r[0]);
      stop();
   endtask : ara
endmodule : dcc_host
`default_nettype wire

/* verif/dcc_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module dcc_regs_bench
   import dcc_pkg::*;
;
   localparam logic [7:0] DW = {DEV_ADDR, 1'b0};
   logic            core_clk_in = 1'b0, rst_in, scl_in, host_sda, power_up_request_in;
   logic            sda_oe_out, alert_oe_out;
   logic [1:0]      gp_ext, card_present_input_n_in, output_feedback_pin_in, overcurrent_in;
   logic [1:0]      input_low_threshold_in, input_high_threshold_in, transistor_short_in;
   logic [1:0]      general_pin_oe_out, fet_on_out, retry_overcurrent_out;
   logic [1:0]      retry_undervoltage_out, retry_overvoltage_out;
   logic [5:0]      fault_log_ch1_in, fault_log_ch2_in;
   int              fails = 0, tests_run = 0;
   // Open-drain lines with pull-ups
   wire logic       sda_in = host_sda & ~sda_oe_out;
   wire logic [1:0] general_pin_in = gp_ext & ~general_pin_oe_out;
   dcc_regs #(.DEBOUNCE_CYCLES(8)) u_dcc_regs (
      .core_clk_in, .rst_in, .scl_in, .sda_in, .sda_out(), .sda_oe_out, .general_pin_in,
      .general_pin_out(), .general_pin_oe_out, .card_present_input_n_in,
      .output_feedback_pin_in, .input_low_threshold_in, .input_high_threshold_in,
      .overcurrent_in, .transistor_short_in, .power_up_request_in, .fault_log_ch1_in,
      .fault_log_ch2_in, .fet_on_out, .retry_overcurrent_out, .retry_undervoltage_out,
      .retry_overvoltage_out, .alert_out(), .alert_oe_out
   );
   dcc_host u_dcc_host (.clk_in(core_clk_in), .sda_in, .scl_out(scl_in), .sda_out(host_sda));
   always #10 core_clk_in = ~core_clk_in;
   task automatic w(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask : w
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      logic       n;
      u_dcc_host.xact(DW, p, d, 1'b0, r, n);
      chk({7'h00, n}, 8'h00);
   endtask : wr
   task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
      logic [7:0] r;
      logic       n;
      u_dcc_host.xact(DW, p, 8'h00, 1'b1, r, n);
      chk({7'h00, n}, 8'h00);
      chk(r, exp);
   endtask : rdc
   // Pin levels from the status bits they should produce
   task automatic drive(input int c, input logic [6:0] v);
      gp_ext[c] <= v[6];
      transistor_short_in[c] <= v[5];
      card_present_input_n_in[c] <= ~v[4];
      output_feedback_pin_in[c] <= ~v[3];
      overcurrent_in[c] <= v[2];
      input_low_threshold_in[c] <= ~v[1];
      input_high_threshold_in[c] <= v[0];
   endtask : drive
   task automatic t_reset();
      rdc(CTL_ADDR[0], 8'h27);
      rdc(CTL_ADDR[1], 8'h37);
      rdc(ALE_ADDR[0], 8'h00);
      rdc(ALE_ADDR[1], 8'h00);
   endtask : t_reset
   task automatic t_ctl();
      wr(CTL_ADDR[0], 8'hFF);
      rdc(CTL_ADDR[0], 8'hEF);
      wr(ALE_ADDR[1], 8'hFF);
      rdc(ALE_ADDR[1], 8'h3F);
      wr(ALE_ADDR[1], 8'h00);
      wr(CTL_ADDR[0], 8'h2A);
      wr(CTL_ADDR[1], 8'h35);
      chk({fet_on_out, retry_overcurrent_out, retry_undervoltage_out, retry_overvoltage_out},
          8'h66);
   endtask : t_ctl
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(CTL_ADDR[0], {m[1:0], 6'h07});
         for (int pb = 0; pb < 2; pb++) begin
            drive(0, {3'b000, pb[0], 3'b000});
            w(8);
            chk({7'h00, general_pin_oe_out[0]},
                {7'h00, (m == 0) ? pb[0] : (m == 1) ? !pb[0] : (m == 2)});
         end
      end
      wr(CTL_ADDR[0], 8'hA7);
      chk({7'h00, general_pin_oe_out[0]}, 8'h00);
   endtask : t_modes
   task automatic t_status();
      logic [6:0] v;
      wr(CTL_ADDR[0], 8'hC8);
      wr(CTL_ADDR[1], 8'hC0);
      for (int k = 0; k < 2; k++) begin
         v = k ? 7'h2A : 7'h55;
         drive(0, v);
         drive(1, ~v);
         w(8);
         rdc(STS_ADDR[0], {1'b1, v});
         rdc(STS_ADDR[1], {1'b0, ~v});
      end
      wr(STS_ADDR[0], 8'h55);
      rdc(STS_ADDR[0], 8'hAA);
      wr(8'hE5, 8'h00);
      rdc(CTL_ADDR[0], 8'hC8);
   endtask : t_status
   task automatic t_bcast();
      logic [7:0] r;
      logic       n;
      u_dcc_host.xact(BCAST_ADDR, CTL_ADDR[0], 8'h05, 1'b0, r, n);
      chk({7'h00, n}, 8'h01);
      rdc(CTL_ADDR[0], 8'hC8);
      wr(CTL_ADDR[1], 8'h10);
      u_dcc_host.xact(BCAST_ADDR, CTL_ADDR[0], 8'h05, 1'b0, r, n);
      chk({7'h00, n}, 8'h00);
      rdc(CTL_ADDR[0], 8'h05);
   endtask : t_bcast
   task automatic t_alert();
      logic [7:0] r;
      logic       n;
      wr(ALE_ADDR[0], 8'h04);
      fault_log_ch1_in <= 6'h01;
      w(6);
      chk({7'h00, alert_oe_out}, 8'h00);
      fault_log_ch1_in <= 6'h05;
      w(4);
      chk({7'h00, alert_oe_out}, 8'h01);
      u_dcc_host.ara(r, n);
      chk(r, {DEV_ADDR, 1'b0});
      chk({7'h00, n}, 8'h00);
      chk({7'h00, alert_oe_out}, 8'h00);
      w(20);
      chk({7'h00, alert_oe_out}, 8'h00);
      fault_log_ch1_in <= 6'h01;
      w(4);
      fault_log_ch1_in <= 6'h05;
      w(4);
      chk({7'h00, alert_oe_out}, 8'h01);
      rdc(ALE_ADDR[0], 8'h04);
      chk({7'h00, alert_oe_out}, 8'h00);
      wr(ALE_ADDR[1], 8'h20);
      fault_log_ch2_in <= 6'h20;
      w(4);
      chk({7'h00, alert_oe_out}, 8'h01);
   endtask : t_alert
   task automatic t_deb();
      power_up_request_in <= 1'b1;
      w(20);
      chk({6'h00, fet_on_out}, 8'h03);
      power_up_request_in <= 1'b0;
      w(20);
      chk({6'h00, fet_on_out}, 8'h00);
   endtask : t_deb
   task automatic conclude();
      $display("tests %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      rst_in = 1'b1;
      power_up_request_in = 1'b0;
      fault_log_ch1_in = 6'h00;
      fault_log_ch2_in = 6'h00;
      drive(0, 7'h00);
      drive(1, 7'h00);
      w(4);
      rst_in <= 1'b0;
      t_reset();
      t_ctl();
      t_modes();
      t_status();
      t_bcast();
      t_alert();
      t_deb();
      conclude();
   end
   // Hang guard
   initial begin
      w(95000);
      fails++;
      conclude();
   end
endmodule : dcc_regs_bench
bind dcc_regs dcc_regs_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (
   .core_clk_in, .rst_in, .scl_in, .sda_out, .sda_oe_out, .general_pin_out,
   .power_up_request_in, .fault_log_ch1_in, .fault_log_ch2_in, .fet_on_out,
   .retry_overcurrent_out, .retry_undervoltage_out, .retry_overvoltage_out,
   .alert_out, .alert_oe_out
);
`default_nettype wire
